/* common/ndac_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte-wide special function register access by the processor core
// Notes:   definitions only, no logic
`ifndef NDAC_REGS_SVH
`define NDAC_REGS_SVH

// register locations (bank, offset)
`define NDAC_BANK_MAIN      8'h00
`define NDAC_BANK_CTRL      8'h01
`define NDAC_OFS_ADDR       8'h2E
`define NDAC_OFS_DATA       8'h2F
`define NDAC_OFS_CTRL       8'h40

// control register field positions
`define NDAC_BIT_STORE_PERMIT 3
`define NDAC_BIT_STORE_GO     2
`define NDAC_BIT_FETCH_PERMIT 1
`define NDAC_BIT_FETCH_GO     0

// reset values
`define NDAC_RST_ADDR       6'h00
`define NDAC_RST_DATA       8'h00
`define NDAC_RST_RDATA      8'h00
`define NDAC_RST_CNT        8'h00

// timing: fixed read length in clocks, write length in timer ticks
`define NDAC_RD_CYCLES      8'h04
`define NDAC_WR_TICKS       8'h04
`define NDAC_CNT_ONE        8'h01

`endif

/* common/ndac_pkg.sv */
// Purpose: shared types of the storage access controller
// Assumes: nothing beyond standard SystemVerilog
// Notes:   sequencer states are one-hot
package ndac_pkg;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    NDAC_IDLE  = 3'h1,
    NDAC_FETCH = 3'h2,
    NDAC_STORE = 3'h4
  } ndac_seq_t;

endpackage : ndac_pkg

/* src/ndac_store.sv */
// Purpose: non-volatile byte array of the storage controller
// Assumes: one write port and one registered read port on the same clock
// Notes:   contents are not reset, as a real array keeps its data
`timescale 1ns/1ps
module ndac_store #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] cell_mem [DEPTH];

  // refuse an array too large for its address
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("ndac_store: DEPTH does not fit AW");
  end

  // write on strobe, read one clock after the address
  always_ff @(posedge clk) begin
    if (we) begin
      cell_mem[waddr] <= wdata;
    end
    rdata <= cell_mem[raddr];
  end

endmodule : ndac_store

/* src/ndac_ctrl.sv */
// Purpose: byte-wide indirect access to the internal non-volatile data store
// Assumes: the core reaches registers as bank plus offset special function registers;
//          the write timer tick comes from a free-running clock of its own
// Notes:   all outputs are registered; the store array sits in ndac_store
//
// Summary of operation
// (R1) up to 128 bytes, small part 64
// (R2) single-byte access through three registers only
// (R3) six-bit address, upper bits read zero
// (R4) eight-bit data register, reset zero
// (R5) control bits 3..0, upper bits zero
// (R6) write trigger starts write, clears at end
// (R7) write trigger without store permit ignored
// (R8) read trigger starts read, clears at end
// (R9) read trigger without fetch permit ignored
// (R10) store permit low blocks every write
// (R11) fetch permit low blocks every read
// (R12) software sets enable before trigger
// (R13) software never sets both triggers
// (R14) read result stays in data register
// (R15) software polls read trigger before reading
// (R16) software polls write trigger or interrupt
// (R17) write timed by asynchronous timer ticks
// (R18) reset clears store permit
// (R19) write end sets storage interrupt flag
// (R20) vector needs flag, enables, stack room
// (R21) control register at bank 1, 40H
// (R22) software sets trigger right after enable
// (R23) read ends after fixed clock count
`timescale 1ns/1ps
`include "ndac_regs.svh"
module ndac_ctrl #(
  parameter int DEPTH = 128,
  parameter int AW    = 6
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // special function register port
  input  wire logic [7:0] sfr_bank,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  // asynchronous write timer tick
  input  wire logic       wtimer_tick,
  // interrupt side
  input  wire logic       nvm_irq_enable,
  input  wire logic       global_irq_enable,
  input  wire logic       stack_full,
  input  wire logic       irq_service,
  output logic            nvm_irq_flag,
  output logic            irq_vector_req,
  // status
  output logic            nvm_busy
);
  import ndac_pkg::*;

  // widths of the array index used by the store
  localparam int SAW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refuse sizes the address register cannot serve
  if (AW < 1 || AW > 7 || DEPTH < (1 << AW) || DEPTH > 128) begin : g_bad_size
    $error("ndac_ctrl: DEPTH or AW out of range");
  end

  // all state of the controller
  typedef struct packed {
    ndac_seq_t        seq;
    logic [AW-1:0]    addr;
    logic [7:0]       data;
    logic             store_permit;
    logic             store_go;
    logic             fetch_permit;
    logic             fetch_go;
    logic [AW-1:0]    cap_addr;
    logic [7:0]       cap_data;
    logic [7:0]       cnt;
    logic             mem_we;
    logic             tick_s1;
    logic             tick_s2;
    logic             tick_d;
    logic             irq_flag;
    logic             vec_req;
    logic [7:0]       rdata;
  } ndac_state_t;

  ndac_state_t st_ff;
  ndac_state_t nxt_st;

  logic [7:0]     mem_rdata;
  logic [SAW-1:0] mem_waddr;
  logic [SAW-1:0] mem_raddr;

  // decoded register selects
  logic sel_addr;
  logic sel_data;
  logic sel_ctrl;
  logic tick_edge;
  logic [7:0] ctrl_view;

  // register decode: address and data live in bank 0, control in bank 1
  assign sel_addr = (sfr_bank == `NDAC_BANK_MAIN) && (sfr_addr == `NDAC_OFS_ADDR); // see (R2)
  assign sel_data = (sfr_bank == `NDAC_BANK_MAIN) && (sfr_addr == `NDAC_OFS_DATA); // see (R2)
  assign sel_ctrl = (sfr_bank == `NDAC_BANK_CTRL) && (sfr_addr == `NDAC_OFS_CTRL); // see (R21)

  // one pulse per timer tick, taken only from the second sync stage
  assign tick_edge = st_ff.tick_s2 & ~st_ff.tick_d; // see (R17)

  // control register as software sees it, upper nibble zero
  always_comb begin
    ctrl_view = 8'h00; // see (R5)
    ctrl_view[`NDAC_BIT_STORE_PERMIT] = st_ff.store_permit;
    ctrl_view[`NDAC_BIT_STORE_GO]     = st_ff.store_go;
    ctrl_view[`NDAC_BIT_FETCH_PERMIT] = st_ff.fetch_permit;
    ctrl_view[`NDAC_BIT_FETCH_GO]     = st_ff.fetch_go;
  end

  // store array addresses, widened to the array index
  assign mem_waddr = SAW'(st_ff.cap_addr); // see (R1)
  assign mem_raddr = SAW'(st_ff.cap_addr);

  ndac_store #(
    .DEPTH (DEPTH),
    .AW    (SAW)
  ) u_store (
    .clk   (clk),
    .we    (st_ff.mem_we),
    .waddr (mem_waddr),
    .wdata (st_ff.cap_data),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // next-state logic of the whole controller
  always_comb begin
    logic wr_go_req;
    logic rd_go_req;
    logic store_done;
    logic fetch_done;
    wr_go_req  = 1'b0;
    rd_go_req  = 1'b0;
    store_done = 1'b0;
    fetch_done = 1'b0;
    nxt_st        = st_ff;
    nxt_st.mem_we = 1'b0;

    // timer tick synchroniser, two stages then an edge register
    nxt_st.tick_s1 = wtimer_tick;
    nxt_st.tick_s2 = st_ff.tick_s1;
    nxt_st.tick_d  = st_ff.tick_s2;

    // plain register writes
    if (sfr_wr && sel_addr) begin
      nxt_st.addr = sfr_wdata[AW-1:0]; // see (R3)
    end
    if (sfr_wr && sel_data) begin
      nxt_st.data = sfr_wdata; // see (R4)
    end
    if (sfr_wr && sel_ctrl) begin
      nxt_st.store_permit = sfr_wdata[`NDAC_BIT_STORE_PERMIT]; // see (R5)
      nxt_st.fetch_permit = sfr_wdata[`NDAC_BIT_FETCH_PERMIT]; // see (R5)
      // a trigger only arms when its permit was already set
      wr_go_req = sfr_wdata[`NDAC_BIT_STORE_GO] & st_ff.store_permit; // see (R7) see (R10)
      rd_go_req = sfr_wdata[`NDAC_BIT_FETCH_GO] & st_ff.fetch_permit; // see (R9) see (R11)
    end

    // sequencer; a running cycle cannot be cut short by software
    unique case (st_ff.seq)
      NDAC_IDLE: begin
        if (wr_go_req) begin
          // write wins if software breaks the one-trigger rule
          nxt_st.seq      = NDAC_STORE; // see (R6)
          nxt_st.store_go = 1'b1;
          nxt_st.cap_addr = st_ff.addr;
          nxt_st.cap_data = st_ff.data;
          nxt_st.cnt      = `NDAC_RST_CNT;
        end else if (rd_go_req) begin
          nxt_st.seq      = NDAC_FETCH; // see (R8)
          nxt_st.fetch_go = 1'b1;
          nxt_st.cap_addr = st_ff.addr;
          nxt_st.cnt      = `NDAC_RST_CNT;
        end
      end
      NDAC_FETCH: begin
        // fixed length, the array answers one clock after its address
        nxt_st.cnt = st_ff.cnt + `NDAC_CNT_ONE; // see (R23)
        if (st_ff.cnt == (`NDAC_RD_CYCLES - `NDAC_CNT_ONE)) begin
          fetch_done = 1'b1;
        end
      end
      NDAC_STORE: begin
        // length set by the slow timer, so clock count varies
        if (tick_edge) begin
          nxt_st.cnt = st_ff.cnt + `NDAC_CNT_ONE; // see (R17)
          if (st_ff.cnt == (`NDAC_WR_TICKS - `NDAC_CNT_ONE)) begin
            store_done = 1'b1;
          end
        end
      end
    endcase

    // end of a read: fetched byte replaces the data register
    if (fetch_done) begin
      nxt_st.seq      = NDAC_IDLE;
      nxt_st.fetch_go = 1'b0; // see (R8)
      nxt_st.data     = mem_rdata; // see (R14)
    end

    // end of a write: commit the captured byte, raise the flag
    if (store_done) begin
      nxt_st.seq      = NDAC_IDLE;
      nxt_st.store_go = 1'b0; // see (R6)
      nxt_st.mem_we   = 1'b1;
    end

    // interrupt flag: service clears, a new write end wins
    if (irq_service) begin
      nxt_st.irq_flag = 1'b0; // see (R20)
    end
    if (store_done) begin
      nxt_st.irq_flag = 1'b1; // see (R19)
    end

    // vector request gated by both enables and stack room
    nxt_st.vec_req = st_ff.irq_flag & nvm_irq_enable & global_irq_enable
                     & ~stack_full & ~irq_service; // see (R20)

    // read data, answered one clock after the strobe
    nxt_st.rdata = 8'h00;
    if (sfr_rd) begin
      if (sel_addr) begin
        nxt_st.rdata = 8'(st_ff.addr); // see (R3)
      end else if (sel_data) begin
        nxt_st.rdata = st_ff.data;
      end else if (sel_ctrl) begin
        nxt_st.rdata = ctrl_view;
      end
    end
  end

  // state register; reset leaves no permit and no trigger set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff.seq          <= NDAC_IDLE;
      st_ff.addr         <= `NDAC_RST_ADDR;
      st_ff.data         <= `NDAC_RST_DATA; // see (R4)
      st_ff.store_permit <= 1'b0; // see (R18)
      st_ff.store_go     <= 1'b0;
      st_ff.fetch_permit <= 1'b0;
      st_ff.fetch_go     <= 1'b0;
      st_ff.cap_addr     <= `NDAC_RST_ADDR;
      st_ff.cap_data     <= `NDAC_RST_DATA;
      st_ff.cnt          <= `NDAC_RST_CNT;
      st_ff.mem_we       <= 1'b0;
      st_ff.tick_s1      <= 1'b0;
      st_ff.tick_s2      <= 1'b0;
      st_ff.tick_d       <= 1'b0;
      st_ff.irq_flag     <= 1'b0;
      st_ff.vec_req      <= 1'b0;
      st_ff.rdata        <= `NDAC_RST_RDATA;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign sfr_rdata      = st_ff.rdata;
  assign nvm_irq_flag   = st_ff.irq_flag;
  assign irq_vector_req = st_ff.vec_req;
  assign nvm_busy       = ~st_ff.seq[0];

endmodule : ndac_ctrl

/* test/ndac_timer_model.sv */
// Purpose: free-running write timer source beside the storage controller
// Assumes: phase unrelated to the system clock
// Notes:   slow stretches the period so write length varies
`timescale 1ns/1ps
module ndac_timer_model (
  // speed select
  input  wire logic slow,
  // tick to the block
  output logic      tick
);
  // own oscillator, never locked to clk
  initial tick = 1'b0;
  always begin
    #(slow ? 53.3 : 23.7);
    tick = ~tick;
  end
endmodule : ndac_timer_model

/* test/ndac_checker.sv */
// Purpose: port checker of the storage access controller
// Assumes: register timing as handed over by the designer
// Notes:   permits are tracked here from control writes
`timescale 1ns/1ps
`include "ndac_regs.svh"
module ndac_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // register port
  input wire logic [7:0] sfr_bank,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // interrupt and status
  input wire logic       irq_service,
  input wire logic       nvm_irq_enable,
  input wire logic       global_irq_enable,
  input wire logic       stack_full,
  input wire logic       nvm_irq_flag,
  input wire logic       irq_vector_req,
  input wire logic       nvm_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] permit_ff;
  logic       ctl_wr;
  // control write decode
  assign ctl_wr = sfr_wr && sfr_bank == `NDAC_BANK_CTRL && sfr_addr == `NDAC_OFS_CTRL;
  // permits as they stood before each write, since triggers look at the old value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      permit_ff <= 2'h0;
    end else if (ctl_wr) begin
      permit_ff <= {sfr_wdata[3], sfr_wdata[1]};
    end
  end
  // cycle shapes
  sequence s_fetch_run;
    nvm_busy [*4] ##1 !nvm_busy;
  endsequence
  sequence s_store_run;
    nvm_busy [*8] ##[1:300] !nvm_busy;
  endsequence
  property p_fetch;
    ctl_wr && sfr_wdata[0] && permit_ff[0] && !sfr_wdata[2] && !nvm_busy |=> s_fetch_run;
  endproperty
  a_fetch: assert property (p_fetch) else $error("read cycle shape wrong");
  property p_store;
    ctl_wr && sfr_wdata[2] && permit_ff[1] && !nvm_busy |=> s_store_run;
  endproperty
  a_store: assert property (p_store) else $error("write cycle shape wrong");
  property p_bare;
    ctl_wr && !nvm_busy && !(sfr_wdata[0] && permit_ff[0])
      && !(sfr_wdata[2] && permit_ff[1]) |=> !nvm_busy;
  endproperty
  a_bare: assert property (p_bare) else $error("cycle without permit");
  property p_flag_rise;
    $rose(nvm_irq_flag) |-> $fell(nvm_busy);
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag off write end");
  property p_flag_hold;
    nvm_irq_flag && !irq_service |=> nvm_irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_flag_clear;
    irq_service && !nvm_busy |=> !nvm_irq_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept");
  property p_vector;
    nvm_irq_flag && nvm_irq_enable && global_irq_enable && !stack_full && !irq_service
      |=> irq_vector_req;
  endproperty
  a_vector: assert property (p_vector) else $error("vector missing");
  property p_rdata_idle;
    !sfr_rd |=> sfr_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule : ndac_checker
bind ndac_ctrl ndac_checker u_chk (
  .clk               (clk),
  .sys_rst           (sys_rst),
  .sfr_bank          (sfr_bank),
  .sfr_addr          (sfr_addr),
  .sfr_wr            (sfr_wr),
  .sfr_wdata         (sfr_wdata),
  .sfr_rd            (sfr_rd),
  .sfr_rdata         (sfr_rdata),
  .irq_service       (irq_service),
  .nvm_irq_enable    (nvm_irq_enable),
  .global_irq_enable (global_irq_enable),
  .stack_full        (stack_full),
  .nvm_irq_flag      (nvm_irq_flag),
  .irq_vector_req    (irq_vector_req),
  .nvm_busy          (nvm_busy)
);

/* test/ndac_ctrl_tb_top.sv */
// Purpose: self-checking bench of the storage access controller
// Assumes: bank/offset register port, timer model on the tick input
// Notes:   inputs other than the timer tick change at the falling edge of clk
`timescale 1ns/1ps
`include "ndac_regs.svh"
module ndac_ctrl_tb_top;
  localparam logic [7:0] bm = `NDAC_BANK_MAIN, bc = `NDAC_BANK_CTRL, oa = `NDAC_OFS_ADDR;
  localparam logic [7:0] od = `NDAC_OFS_DATA, oc = `NDAC_OFS_CTRL;
  logic       clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, slow = 1'b0;
  logic [7:0] sfr_bank = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, got;
  logic       nvm_irq_enable = 1'b0, global_irq_enable = 1'b0, stack_full = 1'b0;
  logic       irq_service = 1'b0, wtimer_tick, nvm_irq_flag, irq_vector_req, nvm_busy;
  int         miscompares = 0, samples_checked = 0, cycles = 0;
  always #5 clk = ~clk;
  ndac_timer_model u_tmr (.slow(slow), .tick(wtimer_tick));
  ndac_ctrl dut (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .sfr_bank          (sfr_bank),
    .sfr_addr          (sfr_addr),
    .sfr_wr            (sfr_wr),
    .sfr_wdata         (sfr_wdata),
    .sfr_rd            (sfr_rd),
    .sfr_rdata         (sfr_rdata),
    .wtimer_tick       (wtimer_tick),
    .nvm_irq_enable    (nvm_irq_enable),
    .global_irq_enable (global_irq_enable),
    .stack_full        (stack_full),
    .irq_service       (irq_service),
    .nvm_irq_flag      (nvm_irq_flag),
    .irq_vector_req    (irq_vector_req),
    .nvm_busy          (nvm_busy)
  );
  // one register write, strobe held over one rising edge
  task automatic wr(input logic [7:0] b, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_bank = b;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  // one register read, data sampled the cycle after the strobe edge
  task automatic rd(input logic [7:0] b, input logic [7:0] a);
    @(negedge clk);
    sfr_bank = b;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    got = sfr_rdata;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // bounded poll of a trigger bit, as software would
  task automatic poll(input logic [7:0] m);
    int n = 0;
    do begin
      rd(bc, oc);
      n++;
    end while ((got & m) !== 8'h00 && n < 300);
    chk(got & m, 8'h00);
  endtask : poll
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic t_regs;
    rd(bc, oc);
    chk(got, 8'h00);
    chk({6'h00, nvm_busy, nvm_irq_flag}, 8'h00);
    rd(bm, od);
    chk(got, 8'h00);
    wr(bm, oa, 8'hFF);
    rd(bm, oa);
    chk(got, 8'h3F);
    wr(bm, od, 8'hA5);
    rd(bm, od);
    chk(got, 8'hA5);
    wr(bc, oc, 8'hF0);
    rd(bc, oc);
    chk(got, 8'h00);
    rd(bm, 8'h30);
    chk(got, 8'h00);
  endtask : t_regs
  // write a byte, take the interrupt, read it back
  task automatic t_round(input logic [7:0] a, input logic [7:0] d);
    nvm_irq_enable = 1'b1;
    global_irq_enable = 1'b0;
    stack_full = 1'b0;
    wr(bm, oa, a);
    wr(bm, od, d);
    wr(bc, oc, 8'h08);
    wr(bc, oc, 8'h0C);
    global_irq_enable = 1'b1;
    rd(bc, oc);
    chk(got, 8'h0C);
    chk({7'h00, nvm_busy}, 8'h01);
    poll(8'h04);
    chk({7'h00, nvm_irq_flag}, 8'h01);
    chk({7'h00, irq_vector_req}, 8'h01);
    stack_full = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, irq_vector_req}, 8'h00);
    irq_service = 1'b1;
    @(negedge clk);
    irq_service = 1'b0;
    @(negedge clk);
    chk({7'h00, nvm_irq_flag}, 8'h00);
    wr(bm, od, 8'h00);
    wr(bc, oc, 8'h02);
    wr(bc, oc, 8'h03);
    poll(8'h01);
    wr(bm, oa, a ^ 8'h01);
    rd(bm, od);
    chk(got, d);
  endtask : t_round
  // triggers without permit must do nothing
  task automatic t_blocked;
    wr(bc, oc, 8'h00);
    wr(bm, oa, 8'h00);
    wr(bm, od, 8'h77);
    wr(bc, oc, 8'h0C);
    rd(bc, oc);
    chk(got, 8'h08);
    wr(bc, oc, 8'h00);
    wr(bc, oc, 8'h04);
    chk({7'h00, nvm_busy}, 8'h00);
    rd(bc, oc);
    chk(got, 8'h00);
    wr(bc, oc, 8'h02);
    wr(bc, oc, 8'h03);
    poll(8'h01);
    rd(bm, od);
    chk(got, 8'h5A);
    wr(bc, oc, 8'h00);
    wr(bm, od, 8'h33);
    wr(bc, oc, 8'h01);
    rd(bc, oc);
    chk(got, 8'h00);
    rd(bm, od);
    chk(got, 8'h33);
  endtask : t_blocked
  // reset with both permits set and no cycle running drops both permits and the data register
  task automatic t_reset;
    wr(bc, oc, 8'h0A);
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd(bc, oc);
    chk(got, 8'h00);
    rd(bm, od);
    chk(got, 8'h00);
    wr(bc, oc, 8'h04);
    chk({7'h00, nvm_busy}, 8'h00);
  endtask : t_reset
  // hang guard, a few hundred cycles are expected
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_round(8'h3F, 8'hA5);
    slow = 1'b1;
    t_round(8'h00, 8'h5A);
    t_blocked();
    t_reset();
    conclude();
  end
endmodule : ndac_ctrl_tb_top
